// ### hdl/tpic_pkg.sv
// Package for the pulse-width timer block: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus with one byte-wide register per aligned word.
package tpic_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte addresses
  localparam logic [7:0] OFS_CTRL_ONE  = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO  = 8'h04;
  localparam logic [7:0] OFS_FLAGS     = 8'h08;
  localparam logic [7:0] OFS_CMP1_HI   = 8'h0C;
  localparam logic [7:0] OFS_CMP1_LO   = 8'h10;
  localparam logic [7:0] OFS_CMP2_HI   = 8'h14;
  localparam logic [7:0] OFS_CMP2_LO   = 8'h18;
  localparam logic [7:0] OFS_CNT_HI    = 8'h1C;
  localparam logic [7:0] OFS_CNT_LO    = 8'h20;
  localparam logic [7:0] OFS_ACNT_HI   = 8'h24;
  localparam logic [7:0] OFS_ACNT_LO   = 8'h28;
  localparam logic [7:0] OFS_CAP1_HI   = 8'h2C;
  localparam logic [7:0] OFS_CAP1_LO   = 8'h30;
  localparam logic [7:0] OFS_CAP2_HI   = 8'h34;
  localparam logic [7:0] OFS_CAP2_LO   = 8'h38;

  // Control one fields
  localparam int unsigned C1_CAP_IE   = 7;
  localparam int unsigned C1_MATCH_IE = 6;
  localparam int unsigned C1_ROLL_IE  = 5;
  localparam int unsigned C1_FORCE2   = 4;
  localparam int unsigned C1_FORCE1   = 3;
  localparam int unsigned C1_LEVEL2   = 2;
  localparam int unsigned C1_EDGE1    = 1;
  localparam int unsigned C1_LEVEL1   = 0;

  // Control two fields
  localparam int unsigned C2_OE1      = 7;
  localparam int unsigned C2_OE2      = 6;
  localparam int unsigned C2_PULSE1   = 5;
  localparam int unsigned C2_PWM      = 4;
  localparam int unsigned C2_SRC_HI   = 3;
  localparam int unsigned C2_SRC_LO   = 2;
  localparam int unsigned C2_EDGE2    = 1;
  localparam int unsigned C2_EXT_EDGE = 0;

  // Tick source codes
  localparam logic [1:0] SRC_DIV4 = 2'h0;
  localparam logic [1:0] SRC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_DIV8 = 2'h2;
  localparam logic [1:0] SRC_EXT  = 2'h3;

  // Flag vector index, status bits 7..3
  localparam int unsigned FL_CAP1 = 4;
  localparam int unsigned FL_M1   = 3;
  localparam int unsigned FL_ROLL = 2;
  localparam int unsigned FL_CAP2 = 1;
  localparam int unsigned FL_M2   = 0;

  // Reset, reload, pulse capture and counter top values
  localparam logic [7:0]  RST_CTRL    = 8'h00;
  localparam logic [15:0] RST_CMP     = 16'h8000;
  localparam logic [15:0] CNT_RELOAD  = 16'hFFFC;
  localparam logic [15:0] PULSE_CAP   = 16'hFFFD;
  localparam logic [15:0] CNT_TOP     = 16'hFFFF;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : tpic_pkg

// ### hdl/tpic_top.sv
// Pulse-width timer with compare outputs, captures, power modes and one interrupt line.
// Assumes an AXI4-Lite master on aclk; CPU mask and power-mode levels come from the core on aclk.
`timescale 1ns/1ns

module tpic_top
  import tpic_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // CPU core state
  input  wire logic              cpu_irq_mask,
  input  wire logic              wait_mode,
  input  wire logic              halt_mode,
  // Pins
  input  wire logic              ext_clk_pin,
  input  wire logic              capture_in_pin_one,
  input  wire logic              capture_in_pin_two,
  output logic                   compare_out_pin_one,
  output logic                   compare_out_pin_one_oe,
  output logic                   compare_out_pin_two,
  output logic                   compare_out_pin_two_oe,
  // Requests to the core
  output logic                   timer_irq,
  output logic                   wake_req
);

  logic [7:0]        timer_control_one_reg;
  logic [7:0]        timer_control_two_reg;
  logic [15:0]       compare_value_one_reg;
  logic [15:0]       compare_value_two_reg;
  logic              inhibit_one_reg;
  logic              inhibit_two_reg;
  logic [15:0]       count_reg;
  logic [15:0]       capture_value_one_reg;
  logic [15:0]       capture_value_two_reg;
  logic [4:0]        flag_reg;
  logic [4:0]        arm_reg;
  logic [2:0]        pre_reg;
  logic [2:0]        ext_sync_reg;
  logic [2:0]        cap1_sync_reg;
  logic [2:0]        cap2_sync_reg;
  logic              ext_lvl_reg;
  logic              cap1_lvl_reg;
  logic              cap2_lvl_reg;
  logic              pend_one_reg;
  logic              pend_two_reg;
  logic              halt_prev_reg;
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [7:0]        wdata_reg;
  logic              wlane_reg;

  // Mode decode
  logic pwm_on;
  logic pulse_on;
  assign pwm_on   = timer_control_two_reg[C2_PWM];
  assign pulse_on = timer_control_two_reg[C2_PULSE1] & ~pwm_on;

  // Synchronised pin levels and edges
  logic ext_lvl_next;
  logic cap1_lvl_next;
  logic cap2_lvl_next;
  assign ext_lvl_next  = (ext_sync_reg[1] == ext_sync_reg[2]) ? ext_sync_reg[2] : ext_lvl_reg;
  assign cap1_lvl_next = (cap1_sync_reg[1] == cap1_sync_reg[2]) ? cap1_sync_reg[2] : cap1_lvl_reg;
  assign cap2_lvl_next = (cap2_sync_reg[1] == cap2_sync_reg[2]) ? cap2_sync_reg[2] : cap2_lvl_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_sync_reg  <= 3'h0;
      cap1_sync_reg <= 3'h0;
      cap2_sync_reg <= 3'h0;
      ext_lvl_reg   <= 1'b0;
      cap1_lvl_reg  <= 1'b0;
      cap2_lvl_reg  <= 1'b0;
    end
    else
    begin
      ext_sync_reg  <= {ext_sync_reg[1:0], ext_clk_pin};
      cap1_sync_reg <= {cap1_sync_reg[1:0], capture_in_pin_one};
      cap2_sync_reg <= {cap2_sync_reg[1:0], capture_in_pin_two};
      ext_lvl_reg   <= ext_lvl_next;
      cap1_lvl_reg  <= cap1_lvl_next;
      cap2_lvl_reg  <= cap2_lvl_next;
    end
  end

  logic ext_edge;
  logic cap1_edge;
  logic cap2_edge;
  assign ext_edge  = (ext_lvl_next != ext_lvl_reg) &&
                     (ext_lvl_next == timer_control_two_reg[C2_EXT_EDGE]);
  assign cap1_edge = (cap1_lvl_next != cap1_lvl_reg) &&
                     (cap1_lvl_next == timer_control_one_reg[C1_EDGE1]) && !pwm_on;
  assign cap2_edge = (cap2_lvl_next != cap2_lvl_reg) &&
                     (cap2_lvl_next == timer_control_two_reg[C2_EDGE2]);

  // Tick generation
  logic [1:0] src_sel;
  logic       tick;
  assign src_sel = timer_control_two_reg[C2_SRC_HI:C2_SRC_LO];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_reg <= 3'h0;
    else if (!halt_mode)
      pre_reg <= pre_reg + 3'h1;
  end

  always_comb
  begin
    case (src_sel)
      SRC_DIV4: tick = (pre_reg[1:0] == 2'h3);
      SRC_DIV2: tick = pre_reg[0];
      SRC_DIV8: tick = (pre_reg == 3'h7);
      default:  tick = ext_edge;
    endcase
    tick = tick & ~halt_mode;
  end

  // Bus access strobes
  logic       wr_fire;
  logic       rd_fire;
  logic [7:0] wr_addr;
  assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign wr_addr = waddr_reg & 8'hFC;

  function automatic logic touched(input logic [7:0] ofs, input logic [7:0] wa, input logic wf,
                                   input logic [7:0] ra, input logic rf);
    touched = (wf && wa == ofs) || (rf && ra == ofs);
  endfunction : touched

  logic [7:0] rd_addr;
  assign rd_addr = s_axi_araddr & 8'hFC;

  // Compare matches
  logic match_one;
  logic match_two;
  assign match_one = tick && !inhibit_one_reg && (count_reg == compare_value_one_reg);
  assign match_two = tick && !inhibit_two_reg && (count_reg == compare_value_two_reg);
  logic cnt_wr;
  assign cnt_wr = wr_fire && wlane_reg && (wr_addr == OFS_CNT_LO || wr_addr == OFS_ACNT_LO);

  // Counter
  logic halt_exit;
  assign halt_exit = halt_prev_reg & ~halt_mode;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_reg <= CNT_RELOAD;
    else if (cnt_wr)
      count_reg <= CNT_RELOAD;
    else if (pwm_on && match_two)
      count_reg <= CNT_RELOAD;
    else if (pulse_on && cap1_edge && !halt_mode)
      count_reg <= CNT_RELOAD;
    else if (tick)
      count_reg <= count_reg + 16'h0001;
  end

  // Captures, including halt arming
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      halt_prev_reg         <= 1'b0;
      pend_one_reg          <= 1'b0;
      pend_two_reg          <= 1'b0;
      capture_value_one_reg <= 16'h0000;
      capture_value_two_reg <= 16'h0000;
    end
    else
    begin
      halt_prev_reg <= halt_mode;
      if (halt_mode && cap1_edge)
        pend_one_reg <= 1'b1;
      else if (halt_exit)
        pend_one_reg <= 1'b0;
      if (halt_mode && cap2_edge)
        pend_two_reg <= 1'b1;
      else if (halt_exit)
        pend_two_reg <= 1'b0;
      if ((halt_exit && pend_one_reg) || (!halt_mode && cap1_edge && !pulse_on))
        capture_value_one_reg <= count_reg;
      else if (!halt_mode && cap1_edge && pulse_on)
        capture_value_one_reg <= PULSE_CAP;
      if ((halt_exit && pend_two_reg) || (!halt_mode && cap2_edge))
        capture_value_two_reg <= count_reg;
    end
  end

  // Flags: set wins over the clear sequence
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  always_comb
  begin
    flag_set          = 5'h00;
    flag_set[FL_CAP1] = (!halt_mode && cap1_edge) || (halt_exit && pend_one_reg) ||
                        (pwm_on && match_two);
    flag_set[FL_M1]   = match_one && !pwm_on && !pulse_on;
    flag_set[FL_M2]   = match_two && !pwm_on;
    flag_set[FL_ROLL] = tick && (count_reg == CNT_TOP) && !cnt_wr;
    flag_set[FL_CAP2] = (!halt_mode && cap2_edge) || (halt_exit && pend_two_reg);
    flag_clr          = 5'h00;
    flag_clr[FL_CAP1] = touched(OFS_CAP1_LO, wr_addr, wr_fire, rd_addr, rd_fire);
    flag_clr[FL_M1]   = touched(OFS_CMP1_LO, wr_addr, wr_fire, rd_addr, rd_fire);
    flag_clr[FL_ROLL] = touched(OFS_CNT_LO, wr_addr, wr_fire, rd_addr, rd_fire);
    flag_clr[FL_CAP2] = touched(OFS_CAP2_LO, wr_addr, wr_fire, rd_addr, rd_fire);
    flag_clr[FL_M2]   = touched(OFS_CMP2_LO, wr_addr, wr_fire, rd_addr, rd_fire);
    flag_clr          = flag_clr & arm_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_reg <= 5'h00;
      arm_reg  <= 5'h00;
    end
    else
    begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
      if (rd_fire && rd_addr == OFS_FLAGS)
        arm_reg <= flag_reg;
      else
        arm_reg <= arm_reg & ~flag_clr & flag_reg;
    end
  end

  // Software registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_control_one_reg <= RST_CTRL;
      timer_control_two_reg <= RST_CTRL;
      compare_value_one_reg <= RST_CMP;
      compare_value_two_reg <= RST_CMP;
      inhibit_one_reg       <= 1'b0;
      inhibit_two_reg       <= 1'b0;
    end
    else if (wr_fire && wlane_reg)
    begin
      case (wr_addr)
        OFS_CTRL_ONE: timer_control_one_reg <= wdata_reg;
        OFS_CTRL_TWO: timer_control_two_reg <= wdata_reg;
        OFS_CMP1_HI:
        begin
          compare_value_one_reg[15:8] <= wdata_reg;
          inhibit_one_reg             <= 1'b1;
        end
        OFS_CMP1_LO:
        begin
          compare_value_one_reg[7:0] <= wdata_reg;
          inhibit_one_reg            <= 1'b0;
        end
        OFS_CMP2_HI:
        begin
          compare_value_two_reg[15:8] <= wdata_reg;
          inhibit_two_reg             <= 1'b1;
        end
        OFS_CMP2_LO:
        begin
          compare_value_two_reg[7:0] <= wdata_reg;
          inhibit_two_reg            <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // Compare output pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      compare_out_pin_one    <= 1'b0;
      compare_out_pin_two    <= 1'b0;
      compare_out_pin_one_oe <= 1'b0;
      compare_out_pin_two_oe <= 1'b0;
    end
    else
    begin
      compare_out_pin_one_oe <= timer_control_two_reg[C2_OE1];
      compare_out_pin_two_oe <= timer_control_two_reg[C2_OE2];
      if (pwm_on)
      begin
        if (match_two)
          compare_out_pin_one <= timer_control_one_reg[C1_LEVEL2];
        else if (match_one)
          compare_out_pin_one <= timer_control_one_reg[C1_LEVEL1];
      end
      else if (pulse_on)
      begin
        if (cap1_edge && !halt_mode)
          compare_out_pin_one <= timer_control_one_reg[C1_LEVEL2];
        else if (match_one)
          compare_out_pin_one <= timer_control_one_reg[C1_LEVEL1];
      end
      else if (match_one || timer_control_one_reg[C1_FORCE1])
        compare_out_pin_one <= timer_control_one_reg[C1_LEVEL1];
      if (pwm_on || pulse_on)
        compare_out_pin_two <= compare_out_pin_two;
      else if (match_two || timer_control_one_reg[C1_FORCE2])
        compare_out_pin_two <= timer_control_one_reg[C1_LEVEL2];
    end
  end

  // Interrupt and wake requests
  logic irq_src;
  assign irq_src = (timer_control_one_reg[C1_CAP_IE] & (flag_reg[FL_CAP1] | flag_reg[FL_CAP2])) |
                   (timer_control_one_reg[C1_MATCH_IE] & (flag_reg[FL_M1] | flag_reg[FL_M2])) |
                   (timer_control_one_reg[C1_ROLL_IE] & flag_reg[FL_ROLL]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_irq <= 1'b0;
      wake_req  <= 1'b0;
    end
    else
    begin
      timer_irq <= irq_src & ~cpu_irq_mask;
      wake_req  <= irq_src & wait_mode & ~halt_mode;
    end
  end

  // AXI4-Lite write channel
  logic wr_hit;
  assign wr_hit = (wr_addr <= OFS_CAP2_LO) && (wr_addr != OFS_FLAGS);
  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      waddr_reg    <= '0;
      wdata_reg    <= 8'h00;
      wlane_reg    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_reg)
      begin
        aw_full_reg <= 1'b1;
        waddr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg)
      begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wlane_reg  <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read channel
  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (rd_addr)
      OFS_CTRL_ONE: rd_byte = timer_control_one_reg;
      OFS_CTRL_TWO: rd_byte = timer_control_two_reg;
      OFS_FLAGS:    rd_byte = {flag_reg, 3'h0};
      OFS_CMP1_HI:  rd_byte = compare_value_one_reg[15:8];
      OFS_CMP1_LO:  rd_byte = compare_value_one_reg[7:0];
      OFS_CMP2_HI:  rd_byte = compare_value_two_reg[15:8];
      OFS_CMP2_LO:  rd_byte = compare_value_two_reg[7:0];
      OFS_CNT_HI:   rd_byte = count_reg[15:8];
      OFS_CNT_LO:   rd_byte = count_reg[7:0];
      OFS_ACNT_HI:  rd_byte = count_reg[15:8];
      OFS_ACNT_LO:  rd_byte = count_reg[7:0];
      OFS_CAP1_HI:  rd_byte = capture_value_one_reg[15:8];
      OFS_CAP1_LO:  rd_byte = capture_value_one_reg[7:0];
      OFS_CAP2_HI:  rd_byte = capture_value_two_reg[15:8];
      OFS_CAP2_LO:  rd_byte = capture_value_two_reg[7:0];
      default:
      begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pwm_reload;
    pwm_on && match_two && !cnt_wr |=> count_reg == CNT_RELOAD;
  endproperty
  a_pwm_reload: assert property (p_pwm_reload) else $error("PWM period end did not reload counter");

  property p_pwm_level_two;
    pwm_on && match_two |=> compare_out_pin_one == $past(timer_control_one_reg[C1_LEVEL2]);
  endproperty
  a_pwm_level_two: assert property (p_pwm_level_two) else $error("Pin one missed level two");

  property p_pwm_level_one;
    pwm_on && match_one && !match_two |=> compare_out_pin_one == $past(timer_control_one_reg[C1_LEVEL1]);
  endproperty
  a_pwm_level_one: assert property (p_pwm_level_one) else $error("Pin one missed level one");

  property p_pwm_no_match_flag;
    pwm_on && $past(pwm_on) |-> !$rose(flag_reg[FL_M1]) && !$rose(flag_reg[FL_M2]);
  endproperty
  a_pwm_no_match_flag: assert property (p_pwm_no_match_flag) else $error("Match flag set in PWM");

  property p_pwm_cap_flag;
    pwm_on && match_two |=> flag_reg[FL_CAP1];
  endproperty
  a_pwm_cap_flag: assert property (p_pwm_cap_flag) else $error("Capture flag one not set at period end");

  property p_inhibit;
    wr_fire && wlane_reg && wr_addr == OFS_CMP1_HI |=> !match_one throughout (inhibit_one_reg [*2]);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("Compare one matched while suspended");

  property p_halt_freeze;
    halt_mode && $past(halt_mode) && !$past(cnt_wr) |-> $stable(count_reg);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("Counter moved during halt");

  property p_irq;
    irq_src && !cpu_irq_mask |=> timer_irq ##1 (timer_irq || !$past(irq_src) || $past(cpu_irq_mask));
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt request missing");

  property p_no_halt_wake;
    halt_mode |=> !wake_req;
  endproperty
  a_no_halt_wake: assert property (p_no_halt_wake) else $error("Timer event woke from halt");

  property p_flag_set_wins;
    flag_set[FL_ROLL] |=> flag_reg[FL_ROLL];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("Rollover event lost");

endmodule : tpic_top

// ### verification/tpic_pin_load.sv
// Load on compare output one: times its high phase and its period in clocks.
// Assumes the pin is driven from flops on aclk by the timer.
`timescale 1ns/1ns
module tpic_pin_load
(
  // Clock and observed pin
  input  wire logic aclk,
  input  wire logic pin,
  // Last measured widths
  output int        high_cyc,
  output int        period_cyc
);
  int   cnt     = 0;
  int   rise_at = 0;
  logic pin_d   = 1'b0;

  always @(posedge aclk)
  begin
    cnt   <= cnt + 1;
    pin_d <= pin;
    if (pin && !pin_d)
    begin
      period_cyc <= cnt - rise_at;
      rise_at    <= cnt;
    end
    if (!pin && pin_d)
      high_cyc <= cnt - rise_at;
  end
endmodule : tpic_pin_load

// ### verification/tb_tpic_top.sv
// Testbench for the pulse-width timer: bus, waveform, flags, interrupt and power modes.
// Assumes tpic_top on one 25 MHz clock with the pin load model on output one.
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_tpic_top import tpic_pkg::*; ;
  logic        aclk = 0, aresetn = 0, cpu_irq_mask = 1, wait_mode = 0, halt_mode = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, d, a;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        ext_clk_pin = 0, capture_in_pin_one = 0, capture_in_pin_two = 0;
  logic        compare_out_pin_one, timer_irq, wake_req;
  logic        compare_out_pin_one_oe, compare_out_pin_two, compare_out_pin_two_oe;
  logic [15:0] c1;
  int          error_cnt = 0, n_compared = 0, high_cyc, period_cyc;
  localparam logic [15:0] C2 = 16'h0040;

  tpic_top i_tpic_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_irq_mask, .wait_mode,
    .halt_mode, .ext_clk_pin, .capture_in_pin_one, .capture_in_pin_two, .compare_out_pin_one,
    .compare_out_pin_one_oe, .compare_out_pin_two, .compare_out_pin_two_oe, .timer_irq, .wake_req);
  tpic_pin_load i_tpic_pin_load (.aclk, .pin(compare_out_pin_one), .high_cyc, .period_cyc);

  initial
  begin
    forever #20 aclk = ~aclk;
  end

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= {24'h0, dt};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
    @(posedge aclk);
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    dt = s_axi_rdata[7:0];
  endtask : rd

  // Clocks per timer tick for each internal source code
  function automatic int presc(input logic [1:0] src);
    return (src == SRC_DIV2) ? 2 : (src == SRC_DIV8) ? 8 : 4;
  endfunction : presc

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (6000) @(posedge aclk);
    error_cnt++;
    summarize();
  end

  initial
  begin
    c1 = 16'($urandom(8));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL_ONE, d);
    `CHK("ctrl1 reset", RST_CTRL, d)
    a = 8'($urandom);
    wr(OFS_CTRL_ONE, a, r);
    rd(OFS_CTRL_ONE, d);
    `CHK("ctrl1 readback", a, d)
    wr(OFS_FLAGS, 8'hFF, r);
    `CHK("flags write resp", RESP_SLVERR, r)
    // Pulse from match one to match two, CAPTURE_IRQ_ENABLE on, level one high
    c1 = 16'h0008 + 16'($urandom % 16);
    wr(OFS_CMP2_HI, C2[15:8], r);
    wr(OFS_CMP2_LO, C2[7:0], r);
    wr(OFS_CMP1_HI, c1[15:8], r);
    wr(OFS_CMP1_LO, c1[7:0], r);
    wr(OFS_CTRL_ONE, 8'h81, r);
    wr(OFS_CTRL_TWO, 8'hB4, r);
    repeat (500) @(posedge aclk);
    `CHK("high width", int'(C2 - c1) * presc(SRC_DIV2), high_cyc)
    `CHK("period", (int'(C2) + 5) * presc(SRC_DIV2), period_cyc)
    `CHK("irq masked", 1'b0, timer_irq)
    `CHK("pin one enable pwm", 1'b1, compare_out_pin_one_oe)
    cpu_irq_mask <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("irq capture", 1'b1, timer_irq)
    rd(OFS_FLAGS, d);
    `CHK("flags", 8'h80, d & 8'hC8)
    wait_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("wake in wait", 1'b1, wake_req)
    halt_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("no wake in halt", 1'b0, wake_req)
    rd(OFS_CNT_LO, a);
    capture_in_pin_two <= 1'b1;
    repeat (8) @(posedge aclk);
    capture_in_pin_two <= 1'b0;
    repeat (12) @(posedge aclk);
    rd(OFS_CNT_LO, d);
    `CHK("halt count", a, d)
    halt_mode <= 1'b0;
    wait_mode <= 1'b0;
    wr(OFS_CTRL_ONE, 8'h05, r);
    repeat (3) @(posedge aclk);
    `CHK("irq blocked", 1'b0, timer_irq)
    rd(OFS_FLAGS, d);
    `CHK("halt capture flag", 8'h10, d & 8'h10)
    rd(OFS_CAP2_LO, d);
    `CHK("halt capture value", a, d)
    repeat (200) @(posedge aclk);
    repeat (4)
    begin
      repeat (37) @(posedge aclk);
      `CHK("steady level", 1'b1, compare_out_pin_one)
    end
    // Falling edges on both capture pins while the waveform runs
    capture_in_pin_one <= 1'b1;
    capture_in_pin_two <= 1'b1;
    repeat (8) @(posedge aclk);
    capture_in_pin_one <= 1'b0;
    capture_in_pin_two <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(OFS_FLAGS, d);
    `CHK("pwm cap2 flag", 8'h10, d & 8'h10)
    rd(OFS_CAP1_LO, d);
    `CHK("cap1 disconnected", 8'h00, d)
    rd(OFS_CAP2_LO, d);
    rd(OFS_FLAGS, d);
    `CHK("cap2 cleared", 8'h00, d & 8'h10)
    // Plain compare mode, pin two enabled, external tick on falling edge
    wr(OFS_CTRL_TWO, 8'h4C, r);
    wr(OFS_CTRL_ONE, 8'h14, r);
    repeat (3) @(posedge aclk);
    `CHK("forced pin two high", 1'b1, compare_out_pin_two)
    `CHK("pin two enable", 1'b1, compare_out_pin_two_oe)
    `CHK("pin one released", 1'b0, compare_out_pin_one_oe)
    rd(OFS_CNT_LO, a);
    repeat (3)
    begin
      ext_clk_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      ext_clk_pin <= 1'b0;
      repeat (6) @(posedge aclk);
    end
    rd(OFS_CNT_LO, d);
    `CHK("external ticks", a + 8'h03, d)
    wr(OFS_CTRL_ONE, 8'h10, r);
    repeat (3) @(posedge aclk);
    `CHK("forced pin two low", 1'b0, compare_out_pin_two)
    summarize();
  end
endmodule : tb_tpic_top
